//--- inc/sas_pkg.sv
// constants for the converter sequencer: register map, field positions, codes
// assumes a 16-bit register port with word addresses
package sas_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned RES_W  = 10;

	// word addresses
	localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO   = 4'h1;
	localparam logic [3:0] ADDR_CTRL_THREE = 4'h2;
	localparam logic [3:0] ADDR_INPUT_SEL  = 4'h3;
	localparam logic [3:0] ADDR_SCAN_SEL   = 4'h4;
	localparam logic [3:0] ADDR_RESULT0    = 4'h5;
	localparam logic [3:0] ADDR_RESULT1    = 4'h6;

	// control one
	localparam int unsigned C1_ON     = 15;
	localparam int unsigned C1_SIDL   = 13;
	localparam int unsigned C1_FORM   = 8;
	localparam int unsigned C1_TRIG   = 5;
	localparam int unsigned C1_AUTO   = 2;
	localparam int unsigned C1_SAMPLE = 1;
	localparam int unsigned C1_DONE   = 0;
	// control two
	localparam int unsigned C2_REF    = 13;
	localparam int unsigned C2_CAL    = 12;
	localparam int unsigned C2_SCAN   = 10;
	localparam int unsigned C2_RATE   = 2;
	localparam int unsigned C2_ALT    = 0;
	// control three
	localparam int unsigned C3_RC     = 15;
	localparam int unsigned C3_EXTSMP = 14;
	localparam int unsigned C3_STIME  = 8;
	localparam int unsigned C3_DIV    = 0;
	// input select
	localparam int unsigned IS_NEG_B  = 15;
	localparam int unsigned IS_POS_B  = 8;
	localparam int unsigned IS_NEG_A  = 7;
	localparam int unsigned IS_POS_A  = 0;
	// scan mask: bit 5 is not implemented
	localparam logic [15:0] SCAN_MASK_IMPL = 16'hffdf;

	localparam logic [15:0] REG_RESET = 16'h0000;

	// format codes
	localparam logic [1:0] FMT_INT   = 2'h0;
	localparam logic [1:0] FMT_SINT  = 2'h1;
	localparam logic [1:0] FMT_FRAC  = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;

	// trigger codes
	localparam logic [2:0] TRIG_SOFT  = 3'h0;
	localparam logic [2:0] TRIG_PIN   = 3'h1;
	localparam logic [2:0] TRIG_TIMER = 3'h2;
	localparam logic [2:0] TRIG_AUTO  = 3'h7;

	typedef enum logic [2:0] {
		ST_HOLD    = 3'b001,
		ST_SAMPLE  = 3'b010,
		ST_CONVERT = 3'b100
	} sas_state_e;
endpackage

//--- hdl/sas_sequencer.sv
// converter sequencer: control registers, sample/convert sequencing, result buffer
// assumes an analog core that converts after conv_start and answers with core_done
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps

module sas_sequencer (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire logic [sas_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [sas_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [sas_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                       device_idle,
	input  wire logic                       rc_osc_tick,
	input  wire logic                       external_interrupt_pin,
	input  wire logic                       timer_match,
	input  wire logic                       core_done,
	input  wire logic [sas_pkg::RES_W-1:0]  core_result,
	output logic                            sh_sample,
	output logic                            conv_start,
	output logic                            conv_clk_tick,
	output logic      [3:0]                 pos_channel,
	output logic                            neg_sel,
	output logic                            ref_pos_ext,
	output logic                            ref_neg_ext,
	output logic                            inputs_tied,
	output logic                            converter_irq_flag
);
	import sas_pkg::*;

	function automatic logic [15:0] fmt_result(input logic [9:0] d, input logic [1:0] f);
		logic [15:0] r;
		r = 16'h0000;
		case (f)
			FMT_INT:   r = {6'h00, d};
			FMT_SINT:  r = {{6{~d[9]}}, ~d[9], d[8:0]};
			FMT_FRAC:  r = {d, 6'h00};
			FMT_SFRAC: r = {~d[9], d[8:0], 6'h00};
			default:   r = {6'h00, d};
		endcase
		return r;
	endfunction

	// next set mask bit after ptr, wrapping; stays put on an empty mask
	function automatic logic [3:0] next_scan(input logic [3:0] ptr, input logic [15:0] mask);
		logic [3:0] r;
		logic       found;
		logic [3:0] cand;
		r = ptr;
		found = 1'b0;
		cand = ptr;
		for (int i = 1; i <= 16; i++) begin
			cand = ptr + 4'(i);
			if (!found && mask[cand]) begin
				r = cand;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	// control fields
	logic        on_r, sidl_r, auto_r, smp_bit_r, done_r;
	logic [1:0]  form_r;
	logic [2:0]  trig_r;
	logic [2:0]  ref_cfg_r;
	logic        cal_r, scan_r, alt_r, rc_r;
	logic [3:0]  rate_r;
	logic [4:0]  stime_r;
	logic [5:0]  div_r;
	logic        neg_b_r, neg_a_r;
	logic [3:0]  pos_b_r, pos_a_r;
	logic [15:0] scan_mask_r;
	logic [15:0] result_r [2];

	sas_state_e  state_r;
	logic [5:0]  div_cnt_r;
	logic [4:0]  smp_cnt_r;
	logic [3:0]  seq_cnt_r;
	logic [3:0]  scan_ptr_r;
	logic        alt_b_r;
	logic        pin_q_r;
	logic        used_a_r;

	// decode
	wire wr_c1 = reg_wr && (reg_addr == ADDR_CTRL_ONE);
	wire wr_c2 = reg_wr && (reg_addr == ADDR_CTRL_TWO);
	wire wr_c3 = reg_wr && (reg_addr == ADDR_CTRL_THREE);
	wire wr_is = reg_wr && (reg_addr == ADDR_INPUT_SEL);
	wire wr_ss = reg_wr && (reg_addr == ADDR_SCAN_SEL);

	wire running  = on_r && !(sidl_r && device_idle);
	wire div_tick = (div_cnt_r == div_r);
	wire cclk_tick = rc_r ? rc_osc_tick : div_tick;
	wire pin_edge = external_interrupt_pin && !pin_q_r;
	wire in_sample_bit  = (state_r == ST_SAMPLE);
	wire ext_smp  = in_sample_bit && !smp_bit_r;
	wire auto_end = cclk_tick && (smp_cnt_r >= stime_r);

	logic end_sample;
	always_comb begin
		case (trig_r)
			TRIG_SOFT:  end_sample = !smp_bit_r;
			TRIG_PIN:   end_sample = pin_edge;
			TRIG_TIMER: end_sample = timer_match;
			TRIG_AUTO:  end_sample = auto_end;
			default:    end_sample = 1'b0;
		endcase
	end

	wire start_sample = running && (state_r == ST_HOLD) && smp_bit_r;
	wire do_convert   = running && in_sample_bit && end_sample;
	wire conv_end     = on_r && (state_r == ST_CONVERT) && core_done;
	wire rate_hit     = (seq_cnt_r == rate_r);
	wire buf_sel      = seq_cnt_r[0];

	// channel picked for the coming sample; alternation and scan pointer step
	// on the same edge that latches it, so the pick looks at their next values
	wire       alt_b_nxt = (conv_end && alt_r) ? !alt_b_r : alt_b_r;
	wire [3:0] scan_nxt  = (conv_end && scan_r && used_a_r) ?
		next_scan(scan_ptr_r, scan_mask_r) : scan_ptr_r;
	wire       use_b    = alt_r && alt_b_nxt;
	wire [3:0] pos_a    = scan_r ? scan_nxt : pos_a_r;
	wire [3:0] pos_pick = cal_r ? 4'h0 : (use_b ? pos_b_r : pos_a);
	wire       neg_pick = cal_r ? 1'b0 : (use_b ? neg_b_r : neg_a_r);

	wire [15:0] rd_c1 = {on_r, 1'b0, sidl_r, 3'h0, form_r, trig_r, 2'h0,
		auto_r, smp_bit_r, done_r};
	wire [15:0] rd_c2 = {ref_cfg_r, cal_r, 1'b0, scan_r, 4'h0, rate_r, 1'b0, alt_r};
	wire [15:0] rd_c3 = {rc_r, ext_smp, 1'b0, stime_r, 2'h0, div_r};
	wire [15:0] rd_is = {neg_b_r, 3'h0, pos_b_r, neg_a_r, 3'h0, pos_a_r};

	logic [15:0] rd_mux;
	always_comb begin
		case (reg_addr)
			ADDR_CTRL_ONE:   rd_mux = rd_c1;
			ADDR_CTRL_TWO:   rd_mux = rd_c2;
			ADDR_CTRL_THREE: rd_mux = rd_c3;
			ADDR_INPUT_SEL:  rd_mux = rd_is;
			ADDR_SCAN_SEL:   rd_mux = scan_mask_r;
			ADDR_RESULT0:    rd_mux = result_r[0];
			ADDR_RESULT1:    rd_mux = result_r[1];
			default:         rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= REG_RESET;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// software-written configuration
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{on_r, sidl_r, auto_r} <= 3'h0;
			form_r <= 2'h0;
			trig_r <= 3'h0;
			{ref_cfg_r, cal_r, scan_r, rate_r, alt_r} <= 10'h000;
			{rc_r, stime_r, div_r} <= 12'h000;
			{neg_b_r, pos_b_r, neg_a_r, pos_a_r} <= 10'h000;
			scan_mask_r <= REG_RESET;
		end else begin
			if (wr_c1) begin
				on_r   <= reg_wdata[C1_ON];
				sidl_r <= reg_wdata[C1_SIDL];
				form_r <= reg_wdata[C1_FORM +: 2];
				trig_r <= reg_wdata[C1_TRIG +: 3];
				auto_r <= reg_wdata[C1_AUTO];
			end
			if (wr_c2) begin
				ref_cfg_r <= reg_wdata[C2_REF +: 3];
				cal_r     <= reg_wdata[C2_CAL];
				scan_r    <= reg_wdata[C2_SCAN];
				rate_r    <= reg_wdata[C2_RATE +: 4];
				alt_r     <= reg_wdata[C2_ALT];
			end
			if (wr_c3) begin
				rc_r    <= reg_wdata[C3_RC];
				stime_r <= reg_wdata[C3_STIME +: 5];
				div_r  <= reg_wdata[C3_DIV +: 6];
			end
			if (wr_is) begin
				neg_b_r <= reg_wdata[IS_NEG_B];
				pos_b_r <= reg_wdata[IS_POS_B +: 4];
				neg_a_r <= reg_wdata[IS_NEG_A];
				pos_a_r <= reg_wdata[IS_POS_A +: 4];
			end
			if (wr_ss)
				scan_mask_r <= reg_wdata & SCAN_MASK_IMPL;
		end
	end

	// sample bit: hardware set wins over a software write in the same cycle;
	// the write that turns the module on may start sampling in the same access
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			smp_bit_r <= 1'b0;
		end else if (!on_r && !wr_c1) begin
			smp_bit_r <= 1'b0;
		end else if (conv_end && auto_r) begin
			smp_bit_r <= 1'b1;
		end else if (do_convert && trig_r != TRIG_SOFT) begin
			smp_bit_r <= 1'b0;
		end else if (wr_c1) begin
			smp_bit_r <= reg_wdata[C1_ON] && reg_wdata[C1_SAMPLE];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			done_r <= 1'b0;
		end else if (!on_r) begin
			done_r <= 1'b0;
		end else if (conv_end) begin
			done_r <= 1'b1;
		end else if (start_sample || (conv_end == 1'b0 && do_convert)) begin
			done_r <= 1'b0;
		end
	end

	// conversion clock divider runs only while the module is on
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_r     <= 6'h00;
			conv_clk_tick <= 1'b0;
			pin_q_r       <= 1'b0;
		end else begin
			div_cnt_r     <= (!on_r || div_tick) ? 6'h00 : div_cnt_r + 6'h01;
			conv_clk_tick <= running && cclk_tick;
			pin_q_r       <= external_interrupt_pin;
		end
	end

	// sequencing state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= ST_HOLD;
			smp_cnt_r  <= 5'h00;
			conv_start <= 1'b0;
		end else if (!on_r) begin
			state_r    <= ST_HOLD;
			smp_cnt_r  <= 5'h00;
			conv_start <= 1'b0;
		end else begin
			conv_start <= do_convert;
			case (state_r)
				ST_HOLD: begin
					smp_cnt_r <= 5'h00;
					if (start_sample)
						state_r <= ST_SAMPLE;
				end
				ST_SAMPLE: begin
					if (do_convert) begin
						state_r   <= ST_CONVERT;
						smp_cnt_r <= 5'h00;
					end else if (running && cclk_tick && smp_cnt_r != 5'h1f) begin
						smp_cnt_r <= smp_cnt_r + 5'h01;
					end
				end
				ST_CONVERT: begin
					if (conv_end)
						state_r <= auto_r ? ST_SAMPLE : ST_HOLD;
				end
				default: state_r <= ST_HOLD;
			endcase
		end
	end

	// result buffer, sequence count, irq; buffer lost on power-down
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_r[0]        <= REG_RESET;
			result_r[1]        <= REG_RESET;
			seq_cnt_r          <= 4'h0;
			converter_irq_flag <= 1'b0;
		end else if (!on_r) begin
			result_r[0]        <= REG_RESET;
			result_r[1]        <= REG_RESET;
			seq_cnt_r          <= 4'h0;
			converter_irq_flag <= 1'b0;
		end else begin
			converter_irq_flag <= conv_end && rate_hit;
			if (conv_end) begin
				result_r[buf_sel] <= fmt_result(core_result, form_r);
				seq_cnt_r         <= rate_hit ? 4'h0 : seq_cnt_r + 4'h1;
			end
		end
	end

	// mux alternation advances once per finished conversion; scan stepping only after a conversion that used input A
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			alt_b_r    <= 1'b0;
			scan_ptr_r <= 4'h0;
			used_a_r   <= 1'b0;
		end else if (!on_r) begin
			alt_b_r    <= 1'b0;
			scan_ptr_r <= next_scan(4'hf, scan_mask_r);
			used_a_r   <= 1'b0;
		end else begin
			if (start_sample || (conv_end && auto_r))
				used_a_r <= !use_b;
			alt_b_r    <= alt_b_nxt;
			scan_ptr_r <= scan_nxt;
		end
	end

	// analog-side controls
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_sample   <= 1'b0;
			pos_channel <= 4'h0;
			neg_sel     <= 1'b0;
			ref_pos_ext <= 1'b0;
			ref_neg_ext <= 1'b0;
			inputs_tied <= 1'b0;
		end else begin
			sh_sample   <= running && in_sample_bit && !do_convert;
			if (start_sample || (conv_end && auto_r)) begin
				pos_channel <= pos_pick;
				neg_sel     <= neg_pick;
			end
			ref_pos_ext <= on_r && !ref_cfg_r[2] && ref_cfg_r[0];
			ref_neg_ext <= on_r && !ref_cfg_r[2] && ref_cfg_r[1];
			inputs_tied <= on_r && cal_r;
		end
	end
endmodule

//--- sim/sas_sequencer_props.sv
// port checks for the converter sequencer
// assumes a bind from the bench top; mirrors control writes to know the mode
`timescale 1ns/10ps
module sas_sequencer_props (
	input wire logic [sas_pkg::ADDR_W-1:0]	reg_addr,
	input wire logic [sas_pkg::DATA_W-1:0]	reg_wdata,
	input wire logic [3:0]	pos_channel,
	input wire logic	core_clk,
	input wire logic	reset_n,
	input wire logic	reg_wr,
	input wire logic	device_idle,
	input wire logic	core_done,
	input wire logic	sh_sample,
	input wire logic	conv_start,
	input wire logic	ref_pos_ext,
	input wire logic	ref_neg_ext,
	input wire logic	inputs_tied,
	input wire logic	converter_irq_flag
);
	import sas_pkg::*;
	logic		on_r;
	logic		auto_r;
	logic		halt_r;
	logic [2:0]	ref_cfg_r;
	wire		wr_one = reg_wr && reg_addr == ADDR_CTRL_ONE;
	wire		wr_two = reg_wr && reg_addr == ADDR_CTRL_TWO;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			on_r <= 1'b0;
			auto_r <= 1'b0;
			halt_r <= 1'b0;
			ref_cfg_r <= 3'h0;
		end else begin
			if (wr_one) begin
				on_r <= reg_wdata[C1_ON];
				auto_r <= reg_wdata[C1_AUTO];
				halt_r <= reg_wdata[C1_SIDL];
			end
			if (wr_two) begin
				ref_cfg_r <= reg_wdata[C2_REF +: 3];
			end
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	start_ends_a: assert property (conv_start |-> $past(sh_sample) && !sh_sample)
		else $error("start without end of sampling");
	// three cycles: write, state, registered output
	off_quiet_a: assert property (!on_r [*3] |-> !sh_sample && !conv_start)
		else $error("activity while off");
	irq_cause_a: assert property (converter_irq_flag |-> $past(core_done))
		else $error("irq without conversion end");
	irq_pulse_a: assert property (converter_irq_flag |=> !converter_irq_flag)
		else $error("irq longer than one cycle");
	cal_chan_a: assert property (conv_start && inputs_tied |-> pos_channel == 4'h0)
		else $error("channel selected in calibration");
	ref_map_a: assert property (on_r && $past(on_r) && $stable(ref_cfg_r) |->
		{ref_pos_ext, ref_neg_ext} == (ref_cfg_r[2] ? 2'b00 : {ref_cfg_r[0], ref_cfg_r[1]}))
		else $error("reference select wrong");
	auto_rearm_a: assert property (core_done && on_r && auto_r &&
		!(halt_r && device_idle) |-> ##[1:4] sh_sample)
		else $error("no automatic sampling");
endmodule

//--- sim/sas_core_model.sv
// stand-in for the analog core: one conversion at a time, fixed latency
// assumes conv_start only while idle; result is base plus conversions so far
`timescale 1ns/10ps
module sas_core_model #(
	parameter int LAT = 3
) (
	input  wire logic	core_clk,
	input  wire logic	reset_n,
	input  wire logic	conv_start,
	input  wire logic [9:0]	base,
	output logic		core_done,
	output logic [9:0]	core_result
);
	int		cnt;
	logic [9:0]	seq;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			seq <= 10'h000;
			core_done <= 1'b0;
			core_result <= 10'h2aa;
		end else begin
			cnt <= conv_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
			core_done <= (cnt == 1);
			seq <= seq + 10'(cnt == 1);
			// toggles outside done so a stale capture is caught
			core_result <= (cnt == 1) ? base + seq : ~core_result;
		end
	end
endmodule

//--- sim/sas_sequencer_tb_top.sv
// self-checking bench for the converter sequencer
// assumes sas_pkg, the design, the core model and the checker are compiled first
`timescale 1ns/10ps
module sas_sequencer_tb_top;
	logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, device_idle = 0;
	logic rc_osc_tick = 0, external_interrupt_pin = 0, timer_match = 0;
	logic core_done, sh_sample, conv_start, conv_clk_tick, neg_sel;
	logic ref_pos_ext, ref_neg_ext, inputs_tied, converter_irq_flag, tied_last;
	logic [3:0]	reg_addr = 4'h0;
	logic [3:0]	pos_channel;
	logic [15:0]	reg_wdata = 16'h0000;
	logic [15:0]	reg_rdata;
	logic [9:0]	core_result, e;
	logic [9:0]	base = 10'h1a5;
	logic [2:0]	trg;
	logic [4:0]	chq[$];
	logic [4:0]	scan_x[4] = '{5'h02, 5'h13, 5'h04, 5'h13};
	int err_count, n_compared, n_start, n_irq, n_done, n_tick, rcc, i, k, s0, s1;

	sas_sequencer uut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .device_idle, .rc_osc_tick, .external_interrupt_pin, .timer_match,
		.core_done, .core_result, .sh_sample, .conv_start, .conv_clk_tick, .pos_channel,
		.neg_sel, .ref_pos_ext, .ref_neg_ext, .inputs_tied, .converter_irq_flag);
	sas_core_model #(.LAT(3)) model (.core_clk, .reset_n, .conv_start, .base, .core_done,
		.core_result);

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (conv_start) begin
			n_start++;
			chq.push_back({neg_sel, pos_channel});
			tied_last = inputs_tied;
		end
		n_irq += converter_irq_flag;
		n_done += core_done;
		n_tick += conv_clk_tick;
		rcc = (rcc == 4) ? 0 : rcc + 1;
		rc_osc_tick <= (rcc == 0);
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] x);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		step();
		reg_wr <= 1'b0;
		step();
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		step();
		reg_rd <= 1'b0;
		chk("read", reg_rdata, x);
		step();
	endtask
	task automatic wait_cnt(ref int c, input int t);
		for (k = 0; k < 600 && c < t; k++) step();
		if (c < t) begin
			err_count++;
			$display("MISMATCH wait exp %0d got %0d", t, c);
			wrap_up();
		end
	endtask
	// core result is offset binary; signed forms flip the top bit
	function automatic logic [15:0] fmtd(input logic [9:0] r, input int f);
		logic [9:0] s;
		s = {~r[9], r[8:0]};
		case (f)
			0: return {6'h00, r};
			1: return {{6{s[9]}}, s};
			2: return {r, 6'h00};
			default: return {s, 6'h00};
		endcase
	endfunction

	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		step();
		for (i = 0; i < 3; i++) rd(4'(i), 16'h0000);
		wr(4'h1, 16'hffc5);
		rd(4'h1, 16'hf405);
		wr(4'h2, 16'hffff);
		rd(4'h2, 16'h9f3f);
		wr(4'hf, 16'hffff);
		rd(4'hf, 16'h0000);
		wr(4'h0, 16'h0001);
		rd(4'h0, 16'h0000);
		wr(4'h1, 16'h0000);
		wr(4'h2, 16'h1f00);
		wr(4'h3, 16'h8309);
		for (i = 0; i < 4; i++) begin
			trg = (i == 0) ? 3'h7 : 3'(i - 1);
			e = base + 10'(n_done);
			wr(4'h0, {6'h20, 2'(i), trg, 5'h02});
			repeat (20) step();
			chk("sampling", sh_sample, 1);
			if (i == 1) wr(4'h0, {6'h20, 2'(i), 8'h00});
			external_interrupt_pin <= (i == 2);
			timer_match <= (i == 3);
			step();
			timer_match <= 1'b0;
			wait_cnt(n_irq, i + 1);
			rd(4'h0, {6'h20, 2'(i), trg, 5'h01});
			rd(4'h5, fmtd(e, i));
			chk("channel", chq[$], 9);
			wr(4'h0, 16'h0000);
			external_interrupt_pin <= 1'b0;
			rd(4'h5, 16'h0000);
		end
		wr(4'h0, 16'h8062);
		external_interrupt_pin <= 1'b1;
		timer_match <= 1'b1;
		step();
		timer_match <= 1'b0;
		repeat (60) step();
		chk("reserved", sh_sample, 1);
		wr(4'h0, 16'h0000);
		external_interrupt_pin <= 1'b0;
		device_idle <= 1'b1;
		s0 = n_start;
		wr(4'h0, 16'ha0e6);
		repeat (60) step();
		chk("idle", 16'(n_start - s0), 0);
		device_idle <= 1'b0;
		wait_cnt(n_start, s0 + 1);
		wr(4'h0, 16'h0000);
		wr(4'h1, 16'h0405);
		wr(4'h4, 16'h0014);
		chq.delete();
		s0 = n_done;
		s1 = n_irq;
		wr(4'h0, 16'h80e6);
		wait_cnt(n_irq, s1 + 1);
		chk("pair", 16'(n_done - s0), 2);
		rd(4'h5, {6'h00, base + 10'(s0)});
		rd(4'h6, {6'h00, base + 10'(s0 + 1)});
		wait_cnt(n_irq, s1 + 2);
		repeat (5) step();
		wr(4'h0, 16'h0000);
		for (i = 0; i < 4; i++) chk("scan", chq[i], scan_x[i]);
		wr(4'h1, 16'h1000);
		s1 = n_irq;
		wr(4'h0, 16'h80e2);
		wait_cnt(n_irq, s1 + 1);
		chk("tied", tied_last, 1);
		chk("cal channel", chq[$], 0);
		rd(4'h5, {6'h00, base + 10'(n_done - 1)});
		wr(4'h0, 16'h8000);
		for (i = 0; i < 8; i++) begin
			wr(4'h1, {3'(i), 13'h0000});
			step();
			chk("ref", {ref_pos_ext, ref_neg_ext}, (i > 3) ? 0 : {i[0], i[1]});
		end
		wr(4'h0, 16'h0000);
		wr(4'h2, 16'h1f03);
		for (i = 0; i < 2; i++) begin
			wr(4'h0, 16'h8002);
			repeat (6) step();
			s0 = n_tick;
			repeat (40) step();
			chk("ticks", 16'(n_tick - s0), i ? 8 : 10);
			wr(4'h0, 16'h0000);
			wr(4'h2, 16'h9f00);
		end
		wrap_up();
	end
endmodule

bind sas_sequencer sas_sequencer_props u_props (.core_clk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .device_idle, .core_done, .sh_sample, .conv_start, .pos_channel, .ref_pos_ext,
	.ref_neg_ext, .inputs_tied, .converter_irq_flag);
